// ---- mis_map.vh ----
// Purpose: register map and field constants for the modem event index/status block
// Assumes: 16-bit register address, 8-bit data
// Notes: offsets are byte addresses in the modem register space
`ifndef MIS_MAP_VH
`define MIS_MAP_VH
`define MIS_ADDR_W 16
`define MIS_OFF_INDEX 16'h2278
`define MIS_OFF_STATUS 16'h227e
`define MIS_OFF_MASK 16'h2277
`define MIS_OFF_IRQ_STAT 16'h2270
`define MIS_OFF_IRQ_MASK 16'h2271
`define MIS_BIT_EXT_RATE 4
`define MIS_BIT_CLR_ALL 3
`define MIS_RST_INDEX 8'hfc
`define MIS_RST_STATUS 8'hff
`define MIS_RST_MASK 4'h0
`define MIS_EVT_MODEM_READY 2'h0
`define MIS_EVT_TX_DONE 2'h1
`define MIS_EVT_RX_BEGIN 2'h2
`define MIS_EVT_RX_DONE 2'h3
`define MIS_RATE_500K 2'h1
`define MIS_RATE_1M 2'h2
`define MIS_QUEUE_DEPTH 8
`endif

// ---- mis_event_queue.v ----
// Purpose: small ordered queue of pending event indices
// Assumes: at most four pushes per cycle, one pop per cycle
// Notes: same-cycle pushes are stored in ascending index order
`timescale 1ns/1ps
`default_nettype none
module mis_event_queue #(
    parameter DEPTH = 8,
    parameter PTR_W = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire [3:0] push_vec,
    input wire pop,
    input wire flush,
    output wire [1:0] head,
    output wire not_empty
);
    localparam [PTR_W:0] CAP = DEPTH[PTR_W:0];
    reg [1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] rd_ptr;
    reg [PTR_W:0] count;
    reg [PTR_W:0] base;
    reg [PTR_W:0] n_take;
    integer i;
    integer j;
    wire do_pop = pop && !flush && (count != {(PTR_W+1){1'b0}});
    wire [PTR_W-1:0] wr_base = rd_ptr + base[PTR_W-1:0];

    // slot of push n: start plus the pushes of lower index in the same cycle
    function [PTR_W-1:0] slot_of;
        input [PTR_W-1:0] start;
        input [3:0] v;
        input integer n;
        integer k;
        begin
            slot_of = start;
            for (k = 0; k < n; k = k + 1) begin
                slot_of = slot_of + {{(PTR_W-1){1'b0}}, v[k]};
            end
        end
    endfunction

    assign head = mem[rd_ptr];
    assign not_empty = (count != {(PTR_W+1){1'b0}});

    // a flush in the same cycle as pushes keeps the new events
    always @* begin
        base = flush ? {(PTR_W+1){1'b0}} : count;
        n_take = {(PTR_W+1){1'b0}};
        for (i = 0; i < 4; i = i + 1) begin
            if (push_vec[i] && ((base + n_take) < CAP)) begin
                n_take = n_take + 1'b1;
            end
        end
    end

    always @(posedge sys_clk) begin
        for (j = 0; j < 4; j = j + 1) begin
            if (push_vec[j] && ({1'b0, slot_of({PTR_W{1'b0}}, push_vec, j)} < n_take)) begin
                mem[slot_of(wr_base, push_vec, j)] <= j[1:0];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            rd_ptr <= {PTR_W{1'b0}};
            count <= {(PTR_W+1){1'b0}};
        end else begin
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= base + n_take - {{PTR_W{1'b0}}, do_pop};
        end
    end
endmodule
`default_nettype wire

// ---- mis_irq_index.v ----
// Purpose: modem event index/status reporting with pending queue and interrupt line
// Assumes: event inputs are single-cycle pulses from logic on sys_clk
// Notes: status bits are active low; a write of one returns a bit to idle
//
// Contract
// - receive-done captures extended-rate flag; rate select 1 is 500k, 2 is 1M
// - events arising together are buffered up to the eight-entry queue depth and served one after another
// - each index read retires the reported event, oldest first
// - writing zero to clear-all bit 3 discards all buffered events
// - index bits 1:0: 0 ready, 1 tx done, 2 rx begin, 3 rx done; reset 00
// - status bits 3:0 one per event in index order, reset 1111
// - a triggered event drives its status bit to zero
// - software writes one to a status bit to return it idle
// - status bit 4 mirrors extended-rate flag of index register; both reset 1
// - event with mask bit zero is neither generated nor queued
`timescale 1ns/1ps
`default_nettype none
`include "mis_map.vh"
module mis_irq_index #(
    parameter QUEUE_DEPTH = `MIS_QUEUE_DEPTH
) (
    input wire sys_clk,
    input wire rst,
    input wire [`MIS_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire modem_ready_event,
    input wire tx_done_event,
    input wire rx_begin_event,
    input wire rx_done_event,
    input wire rx_ext_rate,
    input wire [1:0] rx_rate_select,
    output reg irq
);
    reg [3:0] event_mask;
    reg [3:0] pending_event_bits;
    reg ext_rate_flag;
    reg [1:0] pending_event_index;
    reg [3:0] irq_stat;
    reg [3:0] irq_mask;
    reg [3:0] next_irq_stat;
    reg [3:0] next_bits;
    reg [7:0] next_rdata;
    wire [1:0] q_head;
    wire q_any;
    // the index shows the live queue head, so back-to-back reads retire exactly what they report
    wire [1:0] shown_index = q_any ? q_head : pending_event_index;
    // only the two extended rate classes clear the flag; any other rate code sets it to one
    wire rate_is_ext = rx_ext_rate && ((rx_rate_select == `MIS_RATE_500K) || (rx_rate_select == `MIS_RATE_1M));

    function hit;
        input [`MIS_ADDR_W-1:0] a;
        input [`MIS_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire [3:0] raw_evt = {rx_done_event, rx_begin_event, tx_done_event, modem_ready_event};
    wire [3:0] evt = raw_evt & event_mask;
    wire wr_index = reg_wr && hit(reg_addr, `MIS_OFF_INDEX);
    wire wr_status = reg_wr && hit(reg_addr, `MIS_OFF_STATUS);
    wire rd_index = reg_rd && hit(reg_addr, `MIS_OFF_INDEX);
    wire clr_all = wr_index && !reg_wdata[`MIS_BIT_CLR_ALL];
    // buffered events, ascending order within a cycle, one retired per index read
    mis_event_queue #(
        .DEPTH(QUEUE_DEPTH),
        .PTR_W(3)
    ) u_queue (
        .sys_clk(sys_clk),
        .rst(rst),
        .push_vec(evt),
        .pop(rd_index),
        .flush(clr_all),
        .head(q_head),
        .not_empty(q_any)
    );

    always @* begin
        next_bits = pending_event_bits;
        if (wr_status) begin
            next_bits = next_bits | reg_wdata[3:0];
        end
        if (clr_all) begin
            next_bits = 4'hf;
        end
        next_bits = next_bits & ~evt;
    end

    always @* begin
        next_irq_stat = irq_stat;
        if (reg_wr && hit(reg_addr, `MIS_OFF_IRQ_STAT)) begin
            next_irq_stat = next_irq_stat & ~reg_wdata[3:0];
        end
        next_irq_stat = next_irq_stat | evt;
    end

    always @* begin
        next_rdata = 8'h00;
        if (hit(reg_addr, `MIS_OFF_INDEX)) begin
            next_rdata = {3'b111, ext_rate_flag, 2'b11, shown_index};
        end else if (hit(reg_addr, `MIS_OFF_STATUS)) begin
            next_rdata = {3'b111, ext_rate_flag, pending_event_bits};
        end else if (hit(reg_addr, `MIS_OFF_MASK)) begin
            next_rdata = {4'hf, event_mask};
        end else if (hit(reg_addr, `MIS_OFF_IRQ_STAT)) begin
            next_rdata = {4'h0, irq_stat};
        end else if (hit(reg_addr, `MIS_OFF_IRQ_MASK)) begin
            next_rdata = {4'h0, irq_mask};
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            event_mask <= `MIS_RST_MASK;
            pending_event_bits <= 4'hf;
            ext_rate_flag <= 1'b1;
            pending_event_index <= 2'h0;
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            pending_event_bits <= next_bits;
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            if (reg_wr && hit(reg_addr, `MIS_OFF_MASK)) begin
                event_mask <= reg_wdata[3:0];
            end
            if (reg_wr && hit(reg_addr, `MIS_OFF_IRQ_MASK)) begin
                irq_mask <= reg_wdata[3:0];
            end
            // flag takes the rate class of each unmasked received packet, or bit 4 of an index or status write
            if (evt[`MIS_EVT_RX_DONE]) begin
                ext_rate_flag <= ~rate_is_ext;
            end else if ((wr_index || wr_status) && !evt[`MIS_EVT_RX_DONE]) begin
                ext_rate_flag <= reg_wdata[`MIS_BIT_EXT_RATE];
            end
            if (q_any) begin
                pending_event_index <= q_head;
            end
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- mis_irq_index_properties.sv ----
// Purpose: port-level properties of the modem event index block
// Assumes: bound to mis_irq_index, one clock, sync reset
// Notes: the event enable mask is tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module mis_irq_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic modem_ready_event,
    input wire logic tx_done_event,
    input wire logic rx_begin_event,
    input wire logic rx_done_event,
    input wire logic irq
);
    logic [3:0] en;
    wire logic [3:0] ev = {rx_done_event, rx_begin_event, tx_done_event, modem_ready_event};
    wire logic rd_i = reg_rd && reg_addr == 16'h2278;
    wire logic rd_s = reg_rd && reg_addr == 16'h227e;
    wire logic [3:0] ev_on;
    assign ev_on = ev & en;
    always @(posedge sys_clk)
        if (rst) en <= 4'h0;
        else if (reg_wr && reg_addr == 16'h2277) en <= reg_wdata[3:0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
    AST_IRQ_RESET: assert property ($past(rst) |-> !irq) else $error("irq after reset");
    AST_STS_RSVD: assert property (rd_s |=> reg_rdata[7:5] == 3'h7) else $error("status high bits");
    AST_IDX_RSVD: assert property (rd_i |=> reg_rdata[7:5] == 3'h7 && reg_rdata[2]) else $error("index bits");
    AST_EVT_LOW: assert property ((|ev_on) ##1 rd_s |=> (reg_rdata[3:0] & $past(ev_on, 2)) == 4'h0)
        else $error("event bit not low");
    AST_MIRROR: assert property ((rd_i && !rx_done_event) ##1 (!reg_wr && !rx_done_event) ##1 (rd_s && !rx_done_event)
        |=> reg_rdata[4] == $past(reg_rdata[4], 2)) else $error("flag mirror");
    AST_W1C: assert property ((reg_wr && reg_addr == 16'h227e && reg_wdata[3:0] == 4'hf && ev == 0) ##1 ev == 0
        ##1 rd_s |=> reg_rdata[3:0] == 4'hf) else $error("status not idle");
    AST_CLR_ALL: assert property ((reg_wr && reg_addr == 16'h2278 && !reg_wdata[3] && ev == 0) ##1 ev == 0
        ##1 rd_s |=> reg_rdata[3:0] == 4'hf) else $error("clear all");
endmodule
`default_nettype wire

// ---- tb_mis_irq_index.sv ----
// Purpose: directed bench for the modem event index block
// Assumes: 4 ns clock, sync reset held 20 cycles
// Notes: flag 0 marks an extended-rate packet
`timescale 1ns/1ps
`default_nettype none
module tb_mis_irq_index;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_ext = 0, irq;
    logic [15:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [3:0] ev = 0;
    logic [1:0] rx_sel = 2'h1;
    int error_cnt = 0, total_checks = 0;
    always #2 sys_clk = ~sys_clk;
    mis_irq_index DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_ready_event(ev[0]), .tx_done_event(ev[1]),
        .rx_begin_event(ev[2]), .rx_done_event(ev[3]), .rx_ext_rate(rx_ext), .rx_rate_select(rx_sel), .irq(irq));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk) reg_wr <= 0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_rd <= 0;
        #1 chk(reg_rdata, exp);
    endtask
    task fire(input logic [3:0] v, input logic x);
        @(posedge sys_clk) {ev, rx_ext} <= {v, x};
        @(posedge sys_clk) ev <= 0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task t_reset;
        rd(16'h2278, 8'hfc);
        rd(16'h227e, 8'hff);
        rd(16'h2200, 8'h00);
    endtask
    task t_multi;
        wr(16'h2277, 8'h0f);
        wr(16'h2271, 8'h0f);
        fire(4'ha, 1'b1);
        chk({7'h0, irq}, 8'h01);
        rd(16'h2278, 8'hed);
        rd(16'h227e, 8'he5);
        rd(16'h2278, 8'hef);
        rd(16'h2270, 8'h0a);
        wr(16'h2270, 8'h0f);
        @(posedge sys_clk) #1 chk({7'h0, irq}, 8'h00);
        wr(16'h227e, 8'hff);
        rd(16'h227e, 8'hff);
    endtask
    task t_clr;
        fire(4'h5, 1'b0);
        wr(16'h2278, 8'hf7);
        rd(16'h227e, 8'hff);
        fire(4'h2, 1'b0);
        rd(16'h2278, 8'hfd);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata, ev} <= {1'b1, 16'h2278, 8'hf7, 4'h4};
        @(posedge sys_clk) {reg_wr, ev} <= 5'h00;
        rd(16'h2278, 8'hfe);
    endtask
    task t_mask;
        wr(16'h227e, 8'hff);
        wr(16'h2277, 8'h07);
        fire(4'h8, 1'b1);
        rd(16'h227e, 8'hff);
    endtask
    task t_order;
        @(posedge sys_clk) ev <= 4'h7;
        @(posedge sys_clk) {ev, reg_rd, reg_addr} <= {4'h0, 1'b1, 16'h227e};
        @(posedge sys_clk) reg_addr <= 16'h2278;
        #1 chk(reg_rdata, 8'hf8);
        @(posedge sys_clk) #1 chk(reg_rdata, 8'hfc);
        @(posedge sys_clk) #1 chk(reg_rdata, 8'hfd);
        @(posedge sys_clk) reg_rd <= 0;
        #1 chk(reg_rdata, 8'hfe);
    endtask
    task t_rate;
        wr(16'h2277, 8'h0f);
        wr(16'h227e, 8'hff);
        @(posedge sys_clk) rx_sel <= 2'h2;
        fire(4'h8, 1'b1);
        rd(16'h227e, 8'he7);
        fire(4'h8, 1'b0);
        rd(16'h2278, 8'hff);
        @(posedge sys_clk) rx_sel <= 2'h0;
        fire(4'h8, 1'b1);
        rd(16'h227e, 8'hf7);
    endtask
    task t_rerun;
        @(posedge sys_clk) rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        #1 chk({7'h0, irq}, 8'h00);
        rd(16'h2277, 8'hf0);
        rd(16'h2278, 8'hfc);
        rd(16'h227e, 8'hff);
    endtask
    task summarize;
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        t_reset;
        t_multi;
        t_clr;
        t_mask;
        t_order;
        t_rate;
        t_rerun;
        summarize;
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        summarize;
    end
endmodule
bind mis_irq_index mis_irq_props u_props (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .modem_ready_event(modem_ready_event),
    .tx_done_event(tx_done_event), .rx_begin_event(rx_begin_event), .rx_done_event(rx_done_event), .irq(irq));
`default_nettype wire
